// ==== hdl/rss_pkg.sv ====
// Shared constants and types for the ramp/soak program sequencer.
// Assumes one 10 MHz reference clock; times are counted in whole units.
package rss_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SEC_NS        = 1_000_000_000;
  localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned MIN_SECONDS   = 60;

  // ****************************************************************
  // Ranges and reset values
  // ****************************************************************
  localparam logic [12:0] MAX_TIME       = 13'h1_76F;  // 99:59 as low units
  localparam logic [8:0]  MAX_STEPS      = 9'h190;     // 400 steps
  localparam logic [3:0]  MAX_SET        = 4'hA;       // 10 parameter sets
  localparam logic [3:0]  SET_FIRST      = 4'h1;
  localparam logic [8:0]  STEP_COUNT_RST = 9'h014;     // 20 steps
  localparam logic [12:0] STEP_TIME_RST  = 13'h0001;   // 00:01
  localparam logic [15:0] STEP_SV_RST    = 16'h0000;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    RSS_FAULT_HOLD  = 2'b00,
    RSS_FAULT_RUN   = 2'b01,
    RSS_FAULT_RESET = 2'b10
  } rss_fault_e;

  typedef enum logic [2:0] {
    RSS_IDLE  = 3'b000,
    RSS_DELAY = 3'b001,
    RSS_RUN   = 3'b010,
    RSS_SOAK  = 3'b011,
    RSS_HOLD  = 3'b100
  } rss_state_e;

endpackage

// ==== hdl/rss_sequencer.sv ====
// Ramp/soak program sequencer: one pattern of timed steps with options.
// Assumes all inputs synchronous to i_ref_clk; settings are plain ports.
//
// Notes on behaviour
// - Time unit changes only in reset state
// - Start waits delay in minutes, lamp blinking
// - Delay over: execute, run lamp steady
// - Hold policy: fault freezes, error output driven
// - Run policy: keep advancing, error output driven
// - Reset policy: fault returns to reset state
// - Reset recovery: power return gives reset
// - Continue recovery: power return keeps state
// - Advance command skips step or time
// - Time advance past step end: next step
// - Zero advance time disables time advance
// - Step duration 0..99:59, default one unit
// - Set number 0 inherits; first step 1
// - Step count 0..400, changed only in reset
// - Start step zero makes pattern invalid
// - Start setpoint used only from step 1
// - Pattern repeats count, lowered count ends
// - Step loop repeats start..end given times
// - Ramp-to-flat waits inside zone, lamp lit
// - Soak also for flat first, zero steps
// - Soak timer forces advance; zero waits forever
// - Measured origin for ramp start of 1s+
// - Setpoints clamped to limits and shown
// - Reset output beats error output
`timescale 1ns/1ps
`default_nettype none

module rss_sequencer #(
  parameter int unsigned SEC_CYCLES = rss_pkg::SEC_CYCLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_time_unit_ms,
  input  wire logic [12:0] i_program_start_delay,
  input  wire logic [1:0]  i_fault_policy,
  input  wire logic        i_power_continue,
  input  wire logic        i_power_restored,
  input  wire logic        i_advance_by_time,
  input  wire logic [12:0] i_advance_time,
  input  wire logic        i_run_cmd,
  input  wire logic        i_reset_cmd,
  input  wire logic        i_advance_skip,
  input  wire logic        i_input_fault,
  input  wire logic [8:0]  i_step_count,
  input  wire logic [8:0]  i_start_step,
  input  wire logic [15:0] i_start_setpoint_value,
  input  wire logic [13:0] i_pattern_repeat,
  input  wire logic [8:0]  i_loop_start,
  input  wire logic [8:0]  i_loop_end,
  input  wire logic [13:0] i_loop_repeat,
  input  wire logic [13:0] i_soak_zone,
  input  wire logic [12:0] i_soak_time,
  input  wire logic        i_measured_value_origin,
  input  wire logic [15:0] i_pv,
  input  wire logic [15:0] i_sv_high,
  input  wire logic [15:0] i_sv_low,
  input  wire logic [9:0]  i_out_normal,
  input  wire logic [9:0]  i_out_reset,
  input  wire logic [9:0]  i_out_error,
  input  wire logic        i_step_wr,
  input  wire logic [8:0]  i_step_idx,
  input  wire logic [15:0] i_step_sv,
  input  wire logic [12:0] i_step_time,
  input  wire logic [3:0]  i_step_set,
  output logic      [15:0] o_setpoint,
  output logic      [3:0]  o_set_number,
  output logic      [8:0]  o_step,
  output logic             o_run_lamp,
  output logic             o_guaranteed_soak_wait,
  output logic             o_in_reset,
  output logic      [9:0]  o_output_value,
  output logic             o_time_unit_ms,
  output logic      [8:0]  o_step_count
);

  if (SEC_CYCLES < 2) begin : g_chk
    $error("SEC_CYCLES must be at least 2");
  end

  localparam int SW = $clog2(SEC_CYCLES);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Limit a setpoint to the configured band
  function automatic logic [15:0] clamp_sv(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
    if ($signed(v) > $signed(hi)) return hi;
    if ($signed(v) < $signed(lo)) return lo;
    return v;
  endfunction

  // Linear interpolation from origin to target over the duration
  function automatic logic [15:0] lerp(input logic [15:0] o, input logic [15:0] t,
                                       input logic [12:0] el, input logic [12:0] du);
    int d;
    int q;
    d = int'($signed(t)) - int'($signed(o));
    q = 0;
    if (du != 13'h0000) q = (d * int'(el)) / int'(du);
    return (du == 13'h0000) ? t : 16'(int'($signed(o)) + q);
  endfunction

  // ****************************************************************
  // State and step memory
  // ****************************************************************
  rss_pkg::rss_state_e state;
  logic [15:0] mem_sv   [0:400];
  logic [12:0] mem_time [0:400];
  logic [3:0]  mem_set  [0:400];
  logic [SW-1:0] sec_cnt;
  logic [5:0]  min_cnt;
  logic        blink;
  logic [12:0] delay_cnt;
  logic [8:0]  cur;
  logic [15:0] origin;
  logic [12:0] elapsed;
  logic [12:0] soak_cnt;
  logic        soak_first;
  logic        hold_soak;
  logic [13:0] loop_cnt;
  logic [13:0] pat_cnt;
  logic [3:0]  set_no;

  // Time base: seconds, minutes, unit tick by chosen unit
  wire sec_tick  = (sec_cnt == SW'(SEC_CYCLES - 1));
  wire min_tick  = sec_tick && (min_cnt == 6'(rss_pkg::MIN_SECONDS - 1));
  wire unit_tick = o_time_unit_ms ? sec_tick : min_tick;

  // Current and next step lookups with clamping
  wire [15:0] cur_sv   = clamp_sv(mem_sv[cur], i_sv_low, i_sv_high);
  wire [12:0] cur_time = mem_time[cur];
  wire        loop_wrap = (cur == i_loop_end) && ((loop_cnt + 14'h0001) < i_loop_repeat);
  wire        pat_end   = (cur >= o_step_count);
  wire        pat_again = (pat_cnt + 14'h0001) < i_pattern_repeat;
  wire        done      = pat_end && !loop_wrap && !pat_again;
  wire [8:0]  nxt       = loop_wrap ? i_loop_start : (pat_end ? 9'h001 : cur + 9'h001);
  wire [15:0] nxt_sv    = clamp_sv(mem_sv[nxt], i_sv_low, i_sv_high);
  wire [3:0]  nxt_set   = (mem_set[nxt] == 4'h0) ? set_no : mem_set[nxt];

  // Start point: origin selection and first-step checks
  wire [8:0]  st       = i_start_step;
  wire [15:0] st_sv    = clamp_sv(mem_sv[st], i_sv_low, i_sv_high);
  wire [15:0] ssv_cl   = clamp_sv(i_start_setpoint_value, i_sv_low, i_sv_high);
  wire        mv_use   = i_measured_value_origin && (st_sv != ssv_cl)
                         && (mem_time[st] != 13'h0000);
  wire [15:0] origin0  = (st == 9'h001) ? (mv_use ? i_pv : ssv_cl)
                         : clamp_sv(mem_sv[st - 9'h001], i_sv_low, i_sv_high);
  wire        st_valid = (st != 9'h000) && (st <= o_step_count);
  wire [3:0]  st_set   = (mem_set[st] == 4'h0) ? rss_pkg::SET_FIRST : mem_set[st];

  // Soak zone checks against a flat setpoint
  wire signed [16:0] dev_cur = $signed({i_pv[15], i_pv}) - $signed({cur_sv[15], cur_sv});
  wire signed [16:0] dev_st  = $signed({i_pv[15], i_pv}) - $signed({st_sv[15], st_sv});
  wire [16:0] adev_cur = dev_cur[16] ? 17'(-dev_cur) : 17'(dev_cur);
  wire [16:0] adev_st  = dev_st[16] ? 17'(-dev_st) : 17'(dev_st);
  wire        zone_on  = (i_soak_zone != 14'h0000);
  wire        out_cur  = zone_on && (adev_cur > {3'b000, i_soak_zone});
  wire        soak_go  = (origin != cur_sv) && (nxt_sv == cur_sv) && out_cur && !done;
  wire        soak_st  = (origin0 == st_sv) && zone_on
                         && (adev_st > {3'b000, i_soak_zone});
  wire        soak_end = !out_cur || ((i_soak_time != 13'h0000)
                         && (soak_cnt >= i_soak_time));

  // Step completion, advance and fault handling
  wire        step_over = (elapsed >= cur_time);
  wire [13:0] adv_sum   = {1'b0, elapsed} + {1'b0, i_advance_time};
  wire        adv_time  = i_advance_skip && i_advance_by_time
                          && (i_advance_time != 13'h0000);
  wire        adv_step  = i_advance_skip && !i_advance_by_time;
  wire        adv_next  = adv_step || (adv_time && adv_sum >= {1'b0, cur_time});
  wire        fault_hold = i_input_fault && (i_fault_policy == rss_pkg::RSS_FAULT_HOLD);
  wire        fault_rst  = i_input_fault && (i_fault_policy == rss_pkg::RSS_FAULT_RESET);
  wire        running    = (state == rss_pkg::RSS_RUN) || (state == rss_pkg::RSS_SOAK)
                           || (state == rss_pkg::RSS_HOLD);
  wire        pwr_rst    = i_power_restored && !i_power_continue && running;
  wire        go_next    = ((state == rss_pkg::RSS_RUN) && !soak_go && (step_over || adv_next))
                           || ((state == rss_pkg::RSS_SOAK) && !soak_first && soak_end);
  wire [15:0] next_setpoint = (state == rss_pkg::RSS_IDLE) ? ssv_cl
                              : lerp(origin, cur_sv, elapsed, cur_time);

  // ****************************************************************
  // Step memory writes, reset loads defaults
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int k = 0; k <= 400; k++) begin
        mem_sv[k]   <= rss_pkg::STEP_SV_RST;
        mem_time[k] <= rss_pkg::STEP_TIME_RST;
        mem_set[k]  <= 4'h0;
      end
    end else if (i_step_wr && i_step_idx != 9'h000 && i_step_idx <= rss_pkg::MAX_STEPS
                 && i_step_time <= rss_pkg::MAX_TIME && i_step_set <= rss_pkg::MAX_SET) begin
      mem_sv[i_step_idx]   <= i_step_sv;
      mem_time[i_step_idx] <= i_step_time;
      mem_set[i_step_idx]  <= i_step_set;
    end
  end

  // ****************************************************************
  // Time base and blink
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || state == rss_pkg::RSS_IDLE) begin           // Whole units from start
      sec_cnt <= '0;
      min_cnt <= 6'h00;
      blink   <= 1'b0;
    end else begin
      sec_cnt <= sec_tick ? '0 : sec_cnt + SW'(1);
      if (sec_tick) min_cnt <= min_tick ? 6'h00 : min_cnt + 6'h01;
      if (sec_tick) blink <= !blink;
    end
  end

  // ****************************************************************
  // Sequencer control
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state      <= rss_pkg::RSS_IDLE;
      delay_cnt  <= 13'h0000;
      cur        <= 9'h001;
      origin     <= 16'h0000;
      elapsed    <= 13'h0000;
      soak_cnt   <= 13'h0000;
      soak_first <= 1'b0;
      hold_soak  <= 1'b0;
      loop_cnt   <= 14'h0000;
      pat_cnt    <= 14'h0000;
      set_no     <= rss_pkg::SET_FIRST;
    end else if (i_reset_cmd || pwr_rst || (running && fault_rst)) begin
      state <= rss_pkg::RSS_IDLE;
    end else begin
      case (state)
        rss_pkg::RSS_IDLE: begin
          delay_cnt <= 13'h0000;
          if (i_run_cmd && st_valid) begin
            cur      <= st;
            origin   <= origin0;
            elapsed  <= 13'h0000;
            loop_cnt <= 14'h0000;
            pat_cnt  <= 14'h0000;
            set_no   <= st_set;
            state    <= (i_program_start_delay != 13'h0000) ? rss_pkg::RSS_DELAY
                        : (soak_st ? rss_pkg::RSS_SOAK : rss_pkg::RSS_RUN);
            soak_first <= soak_st;
            soak_cnt   <= 13'h0000;
          end
        end
        rss_pkg::RSS_DELAY: begin
          if (min_tick) delay_cnt <= delay_cnt + 13'h0001;
          if (delay_cnt >= i_program_start_delay) begin
            state      <= soak_st ? rss_pkg::RSS_SOAK : rss_pkg::RSS_RUN;
            soak_first <= soak_st;
          end
        end
        rss_pkg::RSS_RUN: begin
          if (fault_hold) begin
            state     <= rss_pkg::RSS_HOLD;
            hold_soak <= 1'b0;
          end else if (go_next && done) begin
            state <= rss_pkg::RSS_IDLE;
          end else if (step_over && soak_go) begin
            state      <= rss_pkg::RSS_SOAK;
            soak_first <= 1'b0;
            soak_cnt   <= 13'h0000;
          end else if (adv_time && !adv_next) begin
            elapsed <= adv_sum[12:0];
          end else if (unit_tick && !go_next) begin
            elapsed <= elapsed + 13'h0001;
          end
        end
        rss_pkg::RSS_SOAK: begin
          if (fault_hold) begin
            state     <= rss_pkg::RSS_HOLD;
            hold_soak <= 1'b1;
          end else if (soak_first && (!(adev_st > {3'b000, i_soak_zone}) || ((i_soak_time
                       != 13'h0000) && soak_cnt >= i_soak_time))) begin
            state <= rss_pkg::RSS_RUN;
          end else if (go_next) begin
            state <= rss_pkg::RSS_RUN;
          end else if (unit_tick) begin
            soak_cnt <= soak_cnt + 13'h0001;
          end
        end
        rss_pkg::RSS_HOLD: begin
          if (!i_input_fault) state <= hold_soak ? rss_pkg::RSS_SOAK : rss_pkg::RSS_RUN;
        end
        default: state <= rss_pkg::RSS_IDLE;
      endcase
      // Entry into the following step
      if (go_next && !done) begin
        cur      <= nxt;
        origin   <= cur_sv;
        elapsed  <= 13'h0000;
        set_no   <= nxt_set;
        if (cur == i_loop_end) loop_cnt <= loop_wrap ? loop_cnt + 14'h0001 : 14'h0000;
        if (pat_end && !loop_wrap) pat_cnt <= pat_cnt + 14'h0001;
      end
    end
  end

  // ****************************************************************
  // Registered outputs and settings latched in reset state
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_time_unit_ms         <= 1'b0;
      o_step_count           <= rss_pkg::STEP_COUNT_RST;
      o_setpoint             <= 16'h0000;
      o_set_number           <= rss_pkg::SET_FIRST;
      o_step                 <= 9'h000;
      o_run_lamp             <= 1'b0;
      o_guaranteed_soak_wait <= 1'b0;
      o_in_reset             <= 1'b1;
      o_output_value         <= 10'h000;
    end else begin
      if (state == rss_pkg::RSS_IDLE) begin
        o_time_unit_ms <= i_time_unit_ms;
        if (i_step_count <= rss_pkg::MAX_STEPS) o_step_count <= i_step_count;
      end
      o_setpoint             <= next_setpoint;
      o_set_number           <= set_no;
      o_step                 <= (state == rss_pkg::RSS_IDLE) ? 9'h000 : cur;
      o_run_lamp             <= (state == rss_pkg::RSS_DELAY) ? blink : running;
      o_guaranteed_soak_wait <= (state == rss_pkg::RSS_SOAK);
      o_in_reset             <= (state == rss_pkg::RSS_IDLE);
      o_output_value         <= (state == rss_pkg::RSS_IDLE) ? i_out_reset
                                : (i_input_fault ? i_out_error : i_out_normal);
    end
  end

  // ****************************************************************
  // Assertions and covers
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  unit_locked_a: assert property ((state != rss_pkg::RSS_IDLE) |=> $stable(o_time_unit_ms))
    else $error("time unit changed outside reset");
  delay_entry_a: assert property ((state == rss_pkg::RSS_IDLE && i_run_cmd && st_valid
    && !i_reset_cmd && i_program_start_delay != 13'h0000) |=> state == rss_pkg::RSS_DELAY)
    else $error("start delay not entered");
  lamp_steady_a: assert property ((state == rss_pkg::RSS_RUN) ##1 (state == rss_pkg::RSS_RUN)
    |-> o_run_lamp) else $error("run lamp not steady");
  fault_hold_a: assert property ((state == rss_pkg::RSS_RUN && fault_hold && !i_reset_cmd
    && !pwr_rst) |=> state == rss_pkg::RSS_HOLD) else $error("hold not entered on fault");
  fault_reset_a: assert property ((running && fault_rst) |=> state == rss_pkg::RSS_IDLE)
    else $error("fault did not reset program");
  power_reset_a: assert property (pwr_rst |=> state == rss_pkg::RSS_IDLE ##1 o_in_reset)
    else $error("power return did not reset");
  reset_out_a: assert property ((state == rss_pkg::RSS_IDLE) |=>
    o_output_value == $past(i_out_reset)) else $error("reset output not driven");
  soak_lamp_a: assert property ((state == rss_pkg::RSS_SOAK) |=> o_guaranteed_soak_wait)
    else $error("soak lamp not lit");
  set_range_a: assert property ((state != rss_pkg::RSS_IDLE) |->
    (set_no != 4'h0 && set_no <= rss_pkg::MAX_SET)) else $error("set number out of range");

  run_seen_c:  cover property (state == rss_pkg::RSS_DELAY ##1 state == rss_pkg::RSS_RUN);
  soak_seen_c: cover property (state == rss_pkg::RSS_SOAK ##1 state == rss_pkg::RSS_RUN);
  hold_seen_c: cover property (state == rss_pkg::RSS_HOLD ##1 state == rss_pkg::RSS_RUN);

endmodule

`default_nettype wire

// ==== test/rss_plant.sv ====
// Process model for the sequencer bench: a lagging measured value.
// Assumes the setpoint is sampled on the same clock as the sequencer.
`timescale 1ns/1ps
`default_nettype none

module rss_plant #(
  parameter int RATE = 8
) (
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_setpoint,
  output logic      [15:0] o_pv
);
  // ****************************************************************
  // Measured value chases setpoint slowly
  // ****************************************************************
  initial o_pv = 16'h0000;
  // Lag lets the measurement trail a ramp, as a real load does
  always @(posedge i_ref_clk) begin
    if ($signed(o_pv) < $signed(i_setpoint)) begin
      o_pv <= o_pv + 16'(RATE);
    end else if ($signed(o_pv) > $signed(i_setpoint)) begin
      o_pv <= o_pv - 16'(RATE);
    end
  end
endmodule

`default_nettype wire

// ==== test/rss_sequencer_test.sv ====
// Self-checking bench for the ramp/soak sequencer with a process model.
// Assumes a short second (20 cycles) and settings driven on falling edges.
`timescale 1ns/1ps
`default_nettype none

module rss_sequencer_test;
  logic clk = 0, rst = 1, unit_ms = 1, pcont = 0, pwr = 0, by_time = 0;
  logic run = 0, rcmd = 0, skip = 0, fault = 0, wr = 0, origin = 0;
  logic [12:0] delay = 0, adv_t = 0, st_time = 0, stime = 0;
  logic [13:0] prep = 14'h0001, lrep = 14'h0001, zone = 14'h0000;
  logic [1:0]  policy = 0;
  logic [8:0]  count = 9'h003, start = 9'h001, idx = 0, lend = 9'h001;
  logic [15:0] sv = 0, pv, setpoint, start_setpoint_value = 16'h0064, svh = 16'h03E8;
  logic [3:0]  set_no, st_set = 0;
  logic [8:0]  step, step_count;
  logic        lamp, soak, in_rst, unit_o, prev;
  logic [9:0]  out_val;
  int          fail_count = 0, samples_checked = 0, toggles;

  always #50 clk = ~clk;

  rss_plant pm (.i_ref_clk(clk), .i_setpoint(setpoint), .o_pv(pv));

  rss_sequencer #(.SEC_CYCLES(20)) dut (
    .i_ref_clk(clk), .i_rst(rst), .i_time_unit_ms(unit_ms),
    .i_program_start_delay(delay), .i_fault_policy(policy),
    .i_power_continue(pcont), .i_power_restored(pwr), .i_advance_by_time(by_time),
    .i_advance_time(adv_t), .i_run_cmd(run), .i_reset_cmd(rcmd),
    .i_advance_skip(skip), .i_input_fault(fault), .i_step_count(count),
    .i_start_step(start), .i_start_setpoint_value(start_setpoint_value),
    .i_pattern_repeat(prep), .i_loop_start(9'h001), .i_loop_end(lend),
    .i_loop_repeat(lrep), .i_soak_zone(zone), .i_soak_time(stime),
    .i_measured_value_origin(origin), .i_pv(pv), .i_sv_high(svh),
    .i_sv_low(16'h0000), .i_out_normal(10'h064), .i_out_reset(10'h00A),
    .i_out_error(10'h1F4), .i_step_wr(wr), .i_step_idx(idx), .i_step_sv(sv),
    .i_step_time(st_time), .i_step_set(st_set), .o_setpoint(setpoint),
    .o_set_number(set_no), .o_step(step), .o_run_lamp(lamp),
    .o_guaranteed_soak_wait(soak), .o_in_reset(in_rst), .o_output_value(out_val),
    .o_time_unit_ms(unit_o), .o_step_count(step_count));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  // One-cycle command pulse: 0 run, 1 reset, 2 skip, 3 power return
  task automatic cmd(input int k);
    run = (k == 0); rcmd = (k == 1); skip = (k == 2); pwr = (k == 3);
    tick(1);
    {run, rcmd, skip, pwr} = 4'h0;
    tick(3);
  endtask

  task automatic put_step(input logic [8:0] i, input logic [15:0] v, input logic [3:0] s);
    idx = i; sv = v; st_time = 13'h0032; st_set = s; wr = 1;
    tick(1);
    wr = 0;
    tick(1);
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    #2_000_000;
    fail_count++;
    results();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    tick(5);
    check(16'(step_count), 16'h0014);
    check(16'(in_rst), 16'h0001);
    rst = 0;
    tick(2);
    check(16'(step_count), 16'h0003);
    check(16'(unit_o), 16'h0001);
    put_step(9'h001, 16'h0064, 4'h0);
    put_step(9'h002, 16'h1388, 4'h3);
    put_step(9'h003, 16'h1388, 4'h0);
    start = 0;
    cmd(0);
    check(16'(in_rst), 16'h0001);
    start = 1; delay = 13'h0001;
    cmd(0);
    check(16'(in_rst), 16'h0000);
    prev = lamp; toggles = 0;
    for (int i = 0; i < 100; i++) begin
      tick(1);
      if (lamp !== prev) toggles++;
      prev = lamp;
    end
    check(16'(toggles >= 4), 16'h0001);
    tick(1200);
    check(16'(lamp), 16'h0001);
    check(16'(step), 16'h0001);
    check(16'(set_no), 16'h0001);
    unit_ms = 0; count = 9'h005;
    tick(3);
    check(16'(unit_o), 16'h0001);
    check(16'(step_count), 16'h0003);
    unit_ms = 1; count = 9'h003;
    cmd(2);
    check(16'(step), 16'h0002);
    check(16'(set_no), 16'h0003);
    cmd(2);
    check(16'(set_no), 16'h0003);
    check(setpoint, 16'h03E8);
    fault = 1;
    tick(3);
    check(16'(out_val), 16'h01F4);
    check(16'(step), 16'h0003);
    fault = 0;
    tick(3);
    check(16'(out_val), 16'h0064);
    policy = 1; fault = 1;
    tick(3);
    check(16'(out_val), 16'h01F4);
    check(16'(in_rst), 16'h0000);
    fault = 0; policy = 2; pcont = 1;
    cmd(3);
    check(16'(in_rst), 16'h0000);
    pcont = 0;
    cmd(3);
    check(16'(in_rst), 16'h0001);
    fault = 1;
    tick(3);
    check(16'(out_val), 16'h000A);
    fault = 0; delay = 0;
    cmd(0);
    check(16'(lamp), 16'h0001);
    fault = 1;
    tick(3);
    check(16'(in_rst), 16'h0001);
    fault = 0; by_time = 1;
    cmd(0);
    cmd(2);
    check(16'(step), 16'h0001);
    adv_t = 13'h003C;
    cmd(2);
    check(16'(step), 16'h0002);
    adv_t = 13'h0019;
    cmd(2);
    check(setpoint, 16'h0226);
    cmd(1);
    svh = 16'h0320; start_setpoint_value = 16'h07D0;
    tick(3);
    check(setpoint, 16'h0320);
    svh = 16'h03E8; start_setpoint_value = 16'h00C8;
    by_time = 0; lend = 9'h002; lrep = 14'h0002; prep = 14'h0002;
    cmd(0);
    cmd(2);
    cmd(2);
    check(16'(step), 16'h0001);
    cmd(2);
    cmd(2);
    check(16'(step), 16'h0003);
    cmd(2);
    check(16'(step), 16'h0001);
    lrep = 14'h0001; prep = 14'h0001;
    cmd(2);
    cmd(2);
    cmd(2);
    check(16'(in_rst), 16'h0001);
    start = 9'h002;
    cmd(0);
    check(setpoint, 16'h0064);
    cmd(1);
    start = 9'h001;
    tick(150);
    put_step(9'h001, 16'h03E8, 4'h0);
    start_setpoint_value = 16'h0258; origin = 1;
    cmd(0);
    check(setpoint, 16'h00C8);
    cmd(1);
    origin = 0; start_setpoint_value = 16'h03E8; zone = 14'h0064;
    cmd(0);
    check(16'(soak), 16'h0001);
    tick(40);
    check(16'(soak), 16'h0001);
    tick(100);
    check(16'(soak), 16'h0000);
    check(16'(step), 16'h0001);
    cmd(1);
    put_step(9'h001, 16'h0064, 4'h0);
    start_setpoint_value = 16'h0064; stime = 13'h0001;
    cmd(0);
    check(16'(soak), 16'h0001);
    tick(30);
    check(16'(soak), 16'h0000);
    cmd(1);
    check(16'(in_rst), 16'h0001);
    results();
  end
endmodule

`default_nettype wire
